// ===== clkspd_pkg.sv
// package for the clock speed and external bus strobe block
// assumes a single clock domain driven by the crystal input
package clkspd_pkg;

  // clock periods per machine cycle in each speed mode
  localparam int unsigned PERIODS_STD = 12;
  localparam int unsigned PERIODS_DBL = 6;

  // core ticks per machine cycle: one tick per state, six states, so
  // twelve crystal clocks with the divider and six without it
  localparam logic [3:0] PHASE_LAST = 4'h5;

  // machine cycles the reset pin must stay high
  localparam logic [1:0] RESET_HOLD_CYCLES = 2'h2;

  // phase slots of the strobes within a machine cycle
  localparam logic [3:0] ALE_SLOT_A = 4'h0;
  localparam logic [3:0] ALE_SLOT_B = 4'h3;
  localparam logic [3:0] FETCH_SLOT_A = 4'h1;
  localparam logic [3:0] FETCH_SLOT_B = 4'h4;

  // bit position of the speed select in the clock control register
  localparam int unsigned SPEED_SEL_BIT = 0;

  // a request from the core about the coming machine cycle
  typedef struct packed {
    logic ext_data_access;
    logic code_fetch;
  } cycle_req_t;

  // the strobes that leave towards the pins
  typedef struct packed {
    logic addr_latch;
    logic program_fetch_strobe;
  } strobe_t;

  typedef enum logic [1:0] {
    SPD_STANDARD = 2'b00,
    SPD_PENDING_DBL = 2'b01,
    SPD_DOUBLE = 2'b10,
    SPD_PENDING_STD = 2'b11
  } speed_state_t;

endpackage

// ===== pin_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes the pin is asynchronous to mclk_i
module pin_sync
  import clkspd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);

  logic meta_q;
  logic level_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      level_q <= meta_q;
    end
  end

  assign level_o = level_q;

endmodule

// ===== clock_speed_and_bus_strobes.sv
// clock speed selection, reset pin qualification and external bus strobes
// assumes mclk_i is the crystal input; the core sits on the same clock and
// uses core_tick_o as its phase enable; pins arrive asynchronously

// What this block does
// - Reset is asserted while rst_n_i is low, and otherwise only after the reset pin stays high for two machine cycles while clocks run.
// - An address latch strobe is emitted so the outside latch can grab the low address byte.
// - The address latch strobe runs at a sixth of the crystal in standard speed and a third in double speed.
// - One address latch pulse is dropped for each external data access.
// - During external code execution the fetch strobe fires twice per machine cycle in which the core requests a code fetch.
// - Two consecutive fetch strobes are dropped for each external data access.
// - The fetch strobe never fires while code comes from internal memory.
// - In double speed a machine cycle lasts six crystal periods.
// - A divide-by-two stage sits before the phase generator and is bypassed in double speed.
// - A speed change is taken only on a rising edge of the divided crystal clock.
// - Reset leaves standard speed; setting the select gives double speed and clearing returns.
// - The timer and serial time base doubles along with the core in double speed.
// - Bit zero of the clock control register picks twelve or six periods per machine cycle.
module clock_speed_and_bus_strobes
  import clkspd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_i,
  input wire logic external_code_select_n_i,
  input wire logic [7:0] clock_control_register_i,
  input wire cycle_req_t cycle_req_i,
  output logic core_reset_o,
  output logic core_tick_o,
  output logic periph_tick_o,
  output logic double_speed_o,
  output logic cycle_end_o,
  output logic ale_o,
  output logic program_fetch_strobe_n_o
);

  // ****************************************
  // pin inputs
  // ****************************************
  logic reset_pin_s;
  logic ext_code_sel_s;

  pin_sync u_sync_reset (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(reset_pin_i),
    .level_o(reset_pin_s)
  );

  pin_sync u_sync_ea (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(external_code_select_n_i),
    .level_o(ext_code_sel_s)
  );

  // ****************************************
  // divide by two and speed switch
  // ****************************************
  logic div2_q;
  logic div2_rise;
  logic double_speed_select;
  speed_state_t spd_q;
  speed_state_t spd_d;
  logic dbl_active;

  assign double_speed_select = clock_control_register_i[SPEED_SEL_BIT];
  // rising edge of the divided clock happens where div2_q is low now
  assign div2_rise = ~div2_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      div2_q <= 1'b0;
    end else begin
      div2_q <= ~div2_q;
    end
  end

  // request latched, applied on divided rising edge
  always_comb begin
    spd_d = spd_q;
    unique case (spd_q)
      SPD_STANDARD: if (double_speed_select) spd_d = SPD_PENDING_DBL;
      SPD_PENDING_DBL: begin
        if (!double_speed_select) begin
          spd_d = SPD_STANDARD;
        end else if (div2_rise) begin
          spd_d = SPD_DOUBLE;
        end
      end
      SPD_DOUBLE: if (!double_speed_select) spd_d = SPD_PENDING_STD;
      SPD_PENDING_STD: begin
        if (double_speed_select) begin
          spd_d = SPD_DOUBLE;
        end else if (div2_rise) begin
          spd_d = SPD_STANDARD;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      spd_q <= SPD_STANDARD;
    end else begin
      spd_q <= spd_d;
    end
  end

  assign dbl_active = (spd_q == SPD_DOUBLE) || (spd_q == SPD_PENDING_STD);

  // ****************************************
  // phase generator
  // ****************************************
  logic tick;
  logic [3:0] phase_q;
  logic cycle_end;

  // common phase: both candidates tick on a divided rising edge
  assign tick = dbl_active | div2_rise;
  assign cycle_end = tick && (phase_q == PHASE_LAST);

  // six state ticks per machine cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      phase_q <= 4'h0;
    end else if (tick) begin
      phase_q <= cycle_end ? 4'h0 : phase_q + 4'h1;
    end
  end

  // ****************************************
  // reset pin qualification
  // ****************************************
  logic [1:0] hold_q;
  logic core_reset_q;
  logic core_reset_d;
  logic hold_met;

  // two full machine cycles high
  // the first cycle end seen only closes a partial cycle, so one extra is counted
  assign hold_met = hold_q == RESET_HOLD_CYCLES + 2'h1;
  assign core_reset_d = reset_pin_s && (core_reset_q || hold_met);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hold_q <= 2'h0;
      core_reset_q <= 1'b1;
    end else begin
      core_reset_q <= core_reset_d;
      if (!reset_pin_s) begin
        hold_q <= 2'h0;
      end else if (cycle_end && !hold_met) begin
        hold_q <= hold_q + 2'h1;
      end
    end
  end

  // ****************************************
  // external bus strobes
  // ****************************************
  cycle_req_t req_q;
  logic fetch_skip_q;
  logic ale_slot;
  logic fetch_slot;
  logic ale_skip;
  logic ext_code;
  strobe_t strobe_d;
  strobe_t strobe_q;

  // req sampled at machine cycle boundary
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      req_q <= '0;
    end else if (cycle_end) begin
      req_q <= cycle_req_i;
    end
  end

  assign ale_slot = tick && (phase_q == ALE_SLOT_A || phase_q == ALE_SLOT_B);
  assign fetch_slot = tick && (phase_q == FETCH_SLOT_A || phase_q == FETCH_SLOT_B);
  // second latch pulse of a data cycle dropped
  assign ale_skip = req_q.ext_data_access && (phase_q == ALE_SLOT_B);
  // low pin selects external code memory
  assign ext_code = ~ext_code_sel_s;

  // the data cycle uses the bus from mid cycle, so the second fetch of this
  // cycle and the first of the next are the two dropped
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fetch_skip_q <= 1'b0;
    end else if (cycle_end) begin
      fetch_skip_q <= req_q.ext_data_access;
    end
  end

  // latch strobe each half machine cycle
  // fetch strobe gating
  // gated by the next reset value so no strobe overlaps the first reset clock
  always_comb begin
    strobe_d.addr_latch = ale_slot && !ale_skip && !core_reset_d;
    strobe_d.program_fetch_strobe = fetch_slot && !core_reset_d && ext_code && req_q.code_fetch
      && !(req_q.ext_data_access && phase_q == FETCH_SLOT_B)
      && !(fetch_skip_q && phase_q == FETCH_SLOT_A);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      strobe_q <= '0;
    end else begin
      strobe_q <= strobe_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic tick_q;
  logic cycle_end_q;
  logic dbl_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tick_q <= 1'b0;
      cycle_end_q <= 1'b0;
      dbl_q <= 1'b0;
    end else begin
      tick_q <= tick;
      cycle_end_q <= cycle_end;
      dbl_q <= dbl_active;
    end
  end

  assign core_reset_o = core_reset_q;
  assign core_tick_o = tick_q;
  assign periph_tick_o = tick_q;
  assign double_speed_o = dbl_q;
  assign cycle_end_o = cycle_end_q;
  assign ale_o = strobe_q.addr_latch;
  assign program_fetch_strobe_n_o = ~strobe_q.program_fetch_strobe;

endmodule

// ===== clkspd_sva.sv
// assertions for the clock speed and bus strobe block
// assumes a bind to the top module, one clock domain
module clkspd_sva (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reset_pin_i,
  input wire logic external_code_select_n_i,
  input wire logic [7:0] clock_control_register_i,
  input wire logic core_reset_o,
  input wire logic core_tick_o,
  input wire logic periph_tick_o,
  input wire logic double_speed_o,
  input wire logic ale_o,
  input wire logic program_fetch_strobe_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ****
  // run-length helpers
  // ****
  logic [5:0] gap_q, hi_q, ext_q;
  logic ok_q, ds_q;
  // a speed change voids the next gap, it mixes two rates
  always_ff @(posedge mclk_i) begin
    ds_q <= double_speed_o;
    gap_q <= ale_o ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3f};
    hi_q <= reset_pin_i ? hi_q + {5'h00, hi_q != 6'h3f} : 6'h00;
    ext_q <= external_code_select_n_i ? ext_q + {5'h00, ext_q != 6'h3f} : 6'h00;
    if (!rst_n_i || core_reset_o || ds_q != double_speed_o) begin
      ok_q <= 1'b0;
    end else if (ale_o) begin
      ok_q <= 1'b1;
    end
  end
  ale_gap_a: assert property (ale_o |=> !ale_o [*2])
    else $error("ale pulses too close");
  ale_rate_a: assert property (ale_o && ok_q && ds_q == double_speed_o |->
    gap_q == (double_speed_o ? 6'h02 : 6'h05) || gap_q == (double_speed_o ? 6'h05 : 6'h0b))
    else $error("ale period wrong");
  fetch_gap_a: assert property (!program_fetch_strobe_n_o |=> program_fetch_strobe_n_o [*2])
    else $error("fetch strobes too close");
  internal_code_a: assert property (ext_q > 6'h20 |-> program_fetch_strobe_n_o)
    else $error("fetch strobe on internal code");
  reset_gate_a: assert property (core_reset_o |-> !ale_o && program_fetch_strobe_n_o)
    else $error("strobe during core reset");
  reset_len_a: assert property ($rose(core_reset_o) |-> hi_q > (double_speed_o ? 6'h0b : 6'h17))
    else $error("reset from short pin pulse");
  speed_follow_a: assert property ((!core_reset_o && $stable(clock_control_register_i[0])) [*6]
    |-> double_speed_o == clock_control_register_i[0])
    else $error("speed mode not following select");
  dbl_tick_a: assert property (double_speed_o [*3] |-> core_tick_o && periph_tick_o)
    else $error("double speed tick missing");
  std_tick_a: assert property ((!double_speed_o && !clock_control_register_i[0]) [*4] ##0 core_tick_o
    |=> !core_tick_o ##1 core_tick_o)
    else $error("standard tick not halved");
endmodule

bind clock_speed_and_bus_strobes clkspd_sva u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .reset_pin_i(reset_pin_i), .external_code_select_n_i(external_code_select_n_i),
  .clock_control_register_i(clock_control_register_i), .core_reset_o(core_reset_o),
  .core_tick_o(core_tick_o), .periph_tick_o(periph_tick_o), .double_speed_o(double_speed_o),
  .ale_o(ale_o), .program_fetch_strobe_n_o(program_fetch_strobe_n_o));

// ===== ext_mem_model.sv
// external address latch and program memory model
// assumes strobes are registered on mclk_i
module ext_mem_model (
  input wire logic mclk_i,
  input wire logic use_ext_code_i,
  input wire logic ale_i,
  input wire logic program_fetch_strobe_n_i,
  output logic external_code_select_n_o,
  output int latch_cnt_o = 0,
  output int fetch_cnt_o = 0
);
  // select held low for external code
  assign external_code_select_n_o = !use_ext_code_i;
  always @(posedge mclk_i) if (ale_i) latch_cnt_o <= latch_cnt_o + 1;
  always @(posedge mclk_i) if (!program_fetch_strobe_n_i) fetch_cnt_o <= fetch_cnt_o + 1;
endmodule

// ===== testbench.sv
// bench for the clock speed and bus strobe block
// assumes the memory model counts the strobes
module testbench
  import clkspd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic spd;
    logic ext;
    cycle_req_t req;
    logic [7:0] ale;
    logic [7:0] fet;
    logic [7:0] clk;
  } row_t;
  // ****
  // rows: four machine cycles, divider bypass halves the cycle
  // ****
  row_t rows [6] = '{'{1'b0, 1'b1, 2'b01, 8'h08, 8'h08, 8'h30}, '{1'b1, 1'b1, 2'b01, 8'h08, 8'h08, 8'h18},
    '{1'b0, 1'b1, 2'b11, 8'h04, 8'h00, 8'h30}, '{1'b1, 1'b0, 2'b11, 8'h04, 8'h00, 8'h18},
    '{1'b0, 1'b0, 2'b01, 8'h08, 8'h00, 8'h30}, '{1'b1, 1'b1, 2'b00, 8'h08, 8'h00, 8'h18}};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pin = 1'b0;
  logic use_ext = 1'b1;
  logic [7:0] ccr = 8'h00;
  cycle_req_t req = 2'b01;
  logic core_reset, dbl, cyc_end, ale, fetch_n, ext_n;
  int latch_cnt, fetch_cnt, a, f, c, a0, f0;
  int n_errors = 0;
  int compares = 0;
  initial forever #12.5 mclk_i = ~mclk_i;
  clock_speed_and_bus_strobes u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reset_pin_i(pin),
    .external_code_select_n_i(ext_n), .clock_control_register_i(ccr), .cycle_req_i(req),
    .core_reset_o(core_reset), .core_tick_o(), .periph_tick_o(), .double_speed_o(dbl),
    .cycle_end_o(cyc_end), .ale_o(ale), .program_fetch_strobe_n_o(fetch_n));
  ext_mem_model u_mem (.mclk_i(mclk_i), .use_ext_code_i(use_ext), .ale_i(ale),
    .program_fetch_strobe_n_i(fetch_n), .external_code_select_n_o(ext_n),
    .latch_cnt_o(latch_cnt), .fetch_cnt_o(fetch_cnt));
  task check(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %0d got %0d", s, e, g);
    end
  endtask
  // counts strobes and clocks over n machine cycles
  task window(input int n);
    do @(negedge mclk_i); while (cyc_end !== 1'b1);
    a0 = latch_cnt;
    f0 = fetch_cnt;
    c = 0;
    repeat (n) begin
      do begin
        @(negedge mclk_i);
        c++;
      end while (cyc_end !== 1'b1);
    end
    a = latch_cnt - a0;
    f = fetch_cnt - f0;
  endtask
  task test_done();
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      @(posedge mclk_i);
      ccr <= {7'h00, rows[i].spd};
      use_ext <= rows[i].ext;
      req <= rows[i].req;
      window(2);
      window(4);
      check("ale", rows[i].ale, a[7:0]);
      check("fetch", rows[i].fet, f[7:0]);
      check("clocks", rows[i].clk, c[7:0]);
    end
    // a lone data access in double speed
    @(posedge mclk_i);
    use_ext <= 1'b1;
    req <= 2'b01;
    window(2);
    @(posedge mclk_i);
    req <= 2'b11;
    fork
      window(4);
      begin
        do @(negedge mclk_i); while (cyc_end !== 1'b1);
        @(posedge mclk_i);
        req <= 2'b01;
      end
    join
    check("ale", 8'h07, a[7:0]);
    check("fetch", 8'h06, f[7:0]);
    // pin pulse just short of two machine cycles, then a long one
    @(posedge mclk_i);
    pin <= 1'b1;
    repeat (11) @(posedge mclk_i);
    pin <= 1'b0;
    repeat (4) @(negedge mclk_i);
    check("reset", 8'h00, {7'h00, core_reset});
    @(posedge mclk_i);
    pin <= 1'b1;
    repeat (44) @(posedge mclk_i);
    check("reset", 8'h01, {7'h00, core_reset});
    pin <= 1'b0;
    repeat (6) @(negedge mclk_i);
    check("reset", 8'h00, {7'h00, core_reset});
    // reset in mid-run returns to standard speed
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
    check("speed", 8'h00, {7'h00, dbl});
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    window(2);
    window(4);
    check("clocks", 8'h18, c[7:0]);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    test_done();
  end
endmodule
